// >>> hdl/lpi_led_pwm.sv
// led pwm intensity and two-phase blink output stage
`timescale 1ns/100ps
`default_nettype none

module lpi_led_pwm (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// register port, same clock domain
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	output logic [7:0] reg_rdata_out,
	// blink input pin, asynchronous
	input wire logic blink_in,
	// open-drain led outputs
	output logic [8:0] led_out,
	output logic [8:0] led_oe_out
);

	lpi_pkg::lpi_state_type s_r;
	lpi_pkg::lpi_state_type s_nxt;
	lpi_pkg::lpi_pos_type pos;
	logic pwm_run;
	logic phase_one;
	logic [8:0] level;
	logic [1:0] inten_idx;
	logic [7:0] cfg_rd;

	// pwm runs only with a non-zero master nibble
	// oscillator stop control
	assign pwm_run = (s_r.master[7:4] != lpi_pkg::LPI_MASTER_OFF);

	lpi_timebase u_timebase (
		.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in),
		.run_in(pwm_run),
		.pos_out(pos)
	);

	// blink phase choice; stage two of the synchroniser only
	// flip xor input when enabled
	assign phase_one = s_r.cfg.blink_en & (s_r.cfg.flip ^ s_r.blink_sync[1]);

	// per-output level from phase bit, intensity and timebase
	for (genvar i = 0; i < lpi_pkg::LPI_OUTPUTS; i++) begin : g_out
		logic phase_bit;
		logic [3:0] setting;
		logic is_static;
		logic gated;
		logic on_time;
		if (i < lpi_pkg::LPI_PHASE_OUTPUTS) begin : g_reg
			assign phase_bit = phase_one ? s_r.phase1[i] : s_r.phase0[i];
			assign setting = s_r.cfg.global_en ? s_r.master[3:0] :
				s_r.inten[i*4 +: 4];
		end else begin : g_ninth
			assign phase_bit = phase_one ? s_r.cfg.o8_p1 : s_r.cfg.o8_p0;
			assign setting = s_r.master[3:0];
		end
		// full setting is static, no gating
		assign is_static = !pwm_run || (setting == lpi_pkg::LPI_FULL_ON);
		// master and nibble form 240 steps
		assign gated = (pos.slot < s_r.master[7:4]);
		assign on_time = gated && (pos.cycle <= setting);
		assign level[i] = (is_static || on_time) ? phase_bit : ~phase_bit;
	end

	// intensity register index within 0x10-0x13
	assign inten_idx = 2'(reg_addr_in - lpi_pkg::LPI_ADDR_INTEN_FIRST);

	// configuration read-back image; unused bits read zero
	always_comb begin
		cfg_rd = 8'h00;
		cfg_rd[lpi_pkg::LPI_CFG_ENABLE] = s_r.cfg.blink_en;
		cfg_rd[lpi_pkg::LPI_CFG_FLIP] = s_r.cfg.flip;
		cfg_rd[lpi_pkg::LPI_CFG_GLOBAL] = s_r.cfg.global_en;
		cfg_rd[lpi_pkg::LPI_CFG_O8_P0] = s_r.cfg.o8_p0;
		cfg_rd[lpi_pkg::LPI_CFG_O8_P1] = s_r.cfg.o8_p1;
		cfg_rd[lpi_pkg::LPI_CFG_BLINK_STAT] = s_r.blink_sync[1];
	end

	// next state: writes, read data, synchroniser, pin drive
	always_comb begin
		s_nxt = s_r;
		s_nxt.blink_sync = {s_r.blink_sync[0], blink_in};
		if (reg_wr_in) begin
			unique case (reg_addr_in)
				lpi_pkg::LPI_ADDR_PHASE0: begin
					s_nxt.phase0 = reg_wdata_in;
				end
				lpi_pkg::LPI_ADDR_PHASE1: begin
					s_nxt.phase1 = reg_wdata_in;
				end
				lpi_pkg::LPI_ADDR_MASTER: begin
					s_nxt.master = reg_wdata_in;
				end
				lpi_pkg::LPI_ADDR_CONFIG: begin
					s_nxt.cfg.blink_en = reg_wdata_in[lpi_pkg::LPI_CFG_ENABLE];
					s_nxt.cfg.flip = reg_wdata_in[lpi_pkg::LPI_CFG_FLIP];
					s_nxt.cfg.global_en = reg_wdata_in[lpi_pkg::LPI_CFG_GLOBAL];
					s_nxt.cfg.o8_p0 = reg_wdata_in[lpi_pkg::LPI_CFG_O8_P0];
					s_nxt.cfg.o8_p1 = reg_wdata_in[lpi_pkg::LPI_CFG_O8_P1];
				end
				default: begin
					if (reg_addr_in >= lpi_pkg::LPI_ADDR_INTEN_FIRST &&
						reg_addr_in <= lpi_pkg::LPI_ADDR_INTEN_LAST) begin
						s_nxt.inten[inten_idx*8 +: 8] = reg_wdata_in;
					end
				end
			endcase
		end
		// read data follows the address one cycle later
		unique case (reg_addr_in)
			lpi_pkg::LPI_ADDR_PHASE0: begin
				s_nxt.rd_data = s_r.phase0;
			end
			lpi_pkg::LPI_ADDR_PHASE1: begin
				s_nxt.rd_data = s_r.phase1;
			end
			lpi_pkg::LPI_ADDR_MASTER: begin
				s_nxt.rd_data = s_r.master;
			end
			lpi_pkg::LPI_ADDR_CONFIG: begin
				s_nxt.rd_data = cfg_rd;
			end
			default: begin
				if (reg_addr_in >= lpi_pkg::LPI_ADDR_INTEN_FIRST &&
					reg_addr_in <= lpi_pkg::LPI_ADDR_INTEN_LAST) begin
					s_nxt.rd_data = s_r.inten[inten_idx*8 +: 8];
				end else begin
					s_nxt.rd_data = 8'h00; // unmapped reads zero
				end
			end
		endcase
		// level 0 sinks, level 1 released
		s_nxt.sink_oe = ~level;
	end

	// state register; outputs released during reset
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_r.phase0 <= lpi_pkg::LPI_PHASE_RST;
			s_r.phase1 <= lpi_pkg::LPI_PHASE_RST;
			s_r.master <= lpi_pkg::LPI_MASTER_RST;
			s_r.cfg.blink_en <= lpi_pkg::LPI_CFG_BIT_RST;
			s_r.cfg.flip <= lpi_pkg::LPI_CFG_BIT_RST;
			s_r.cfg.global_en <= lpi_pkg::LPI_CFG_BIT_RST;
			s_r.cfg.o8_p0 <= lpi_pkg::LPI_O8_LEVEL_RST;
			s_r.cfg.o8_p1 <= lpi_pkg::LPI_O8_LEVEL_RST;
			s_r.inten <= lpi_pkg::LPI_INTEN_RST;
			s_r.blink_sync <= 2'h0;
			s_r.rd_data <= 8'h00;
			s_r.sink_oe <= 9'h000;
		end else begin
			s_r <= s_nxt;
		end
	end

	// open-drain pins only ever drive low
	assign led_out = 9'h000;
	assign led_oe_out = s_r.sink_oe;
	assign reg_rdata_out = s_r.rd_data;

endmodule
`default_nettype wire

// >>> hdl/lpi_pkg.sv
// constants and carrier types for the led pwm intensity and blink block
package lpi_pkg;

	// register addresses
	localparam logic [7:0] LPI_ADDR_PHASE0 = 8'h01;
	localparam logic [7:0] LPI_ADDR_PHASE1 = 8'h09;
	localparam logic [7:0] LPI_ADDR_MASTER = 8'h0E;
	localparam logic [7:0] LPI_ADDR_CONFIG = 8'h0F;
	localparam logic [7:0] LPI_ADDR_INTEN_FIRST = 8'h10;
	localparam logic [7:0] LPI_ADDR_INTEN_LAST = 8'h13;

	// reset values
	localparam logic [7:0] LPI_PHASE_RST = 8'hFF;
	localparam logic [7:0] LPI_MASTER_RST = 8'h00;
	localparam logic [31:0] LPI_INTEN_RST = 32'hFFFFFFFF;
	localparam logic LPI_CFG_BIT_RST = 1'h0;
	localparam logic LPI_O8_LEVEL_RST = 1'h1;

	// configuration register field positions
	localparam int LPI_CFG_ENABLE = 0;
	localparam int LPI_CFG_FLIP = 1;
	localparam int LPI_CFG_GLOBAL = 2;
	localparam int LPI_CFG_O8_P0 = 4;
	localparam int LPI_CFG_O8_P1 = 5;
	localparam int LPI_CFG_BLINK_STAT = 6;

	// pwm structure
	localparam int LPI_OUTPUTS = 9;
	localparam int LPI_PHASE_OUTPUTS = 8;
	localparam logic [3:0] LPI_LAST_SLOT = 4'hE;
	localparam logic [3:0] LPI_LAST_CYCLE = 4'hF;
	localparam logic [3:0] LPI_FULL_ON = 4'hF;
	localparam logic [3:0] LPI_MASTER_OFF = 4'h0;

	// oscillator timing
	localparam int LPI_CLK_HZ = 25000000;
	localparam int LPI_OSC_HZ = 32000;
	localparam int LPI_OSC_DIV = LPI_CLK_HZ / LPI_OSC_HZ;
	localparam int LPI_DIV_W = 10;
	localparam logic [LPI_DIV_W-1:0] LPI_DIV_LAST =
		LPI_DIV_W'(LPI_OSC_DIV - 1);

	// pwm position handed from the timebase
	typedef struct packed {
		logic [3:0] slot;
		logic [3:0] cycle;
	} lpi_pos_type;

	// timebase state
	typedef struct packed {
		logic [LPI_DIV_W-1:0] div;
		lpi_pos_type pos;
	} lpi_tb_state_type;

	// configuration bits
	typedef struct packed {
		logic o8_p1;
		logic o8_p0;
		logic global_en;
		logic flip;
		logic blink_en;
	} lpi_cfg_type;

	// main block state
	typedef struct packed {
		logic [7:0] phase0;
		logic [7:0] phase1;
		logic [7:0] master;
		lpi_cfg_type cfg;
		logic [31:0] inten;
		logic [1:0] blink_sync;
		logic [7:0] rd_data;
		logic [8:0] sink_oe;
	} lpi_state_type;

endpackage

// >>> hdl/lpi_timebase.sv
// internal pwm oscillator, cycle and timeslot counters
`timescale 1ns/100ps
`default_nettype none

module lpi_timebase (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// control
	input wire logic run_in,
	// pwm position
	output lpi_pkg::lpi_pos_type pos_out
);

	lpi_pkg::lpi_tb_state_type s_r;
	lpi_pkg::lpi_tb_state_type s_nxt;

	// divider makes the oscillator tick; held at zero while stopped
	always_comb begin
		s_nxt = s_r;
		if (!run_in) begin
			s_nxt = '0;
		end else if (s_r.div == lpi_pkg::LPI_DIV_LAST) begin
			s_nxt.div = '0;
			if (s_r.pos.cycle == lpi_pkg::LPI_LAST_CYCLE) begin
				s_nxt.pos.cycle = '0;
				if (s_r.pos.slot == lpi_pkg::LPI_LAST_SLOT) begin
					s_nxt.pos.slot = '0;
				end else begin
					s_nxt.pos.slot = s_r.pos.slot + 4'h1;
				end
			end else begin
				s_nxt.pos.cycle = s_r.pos.cycle + 4'h1;
			end
		end else begin
			s_nxt.div = s_r.div + 10'h001;
		end
	end

	// state register
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pos_out = s_r.pos;

endmodule
`default_nettype wire

// >>> tb/lpi_host.sv
// host model driving the register port of the led block
`timescale 1ns/100ps
`default_nettype none
module lpi_host (
	// clock
	input wire logic core_clk_in,
	// register port
	input wire logic [7:0] rdata_in,
	output logic [7:0] addr_out,
	output logic [7:0] wdata_out,
	output logic wr_out
);
	// idle values at time zero
	initial begin
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'b0;
	end
	// one-cycle write strobe, data scrambled after the write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge core_clk_in);
		wr_out <= 1'b0;
		wdata_out <= ~d;
	endtask
	// read data is registered, so wait two edges
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge core_clk_in);
		addr_out <= a;
		repeat (2) @(posedge core_clk_in);
		#1 d = rdata_in;
	endtask
endmodule
`default_nettype wire

// >>> tb/lpi_led_pwm_bench.sv
// self-checking bench for the led pwm block
`timescale 1ns/100ps
`default_nettype none
module lpi_led_pwm_bench;
	typedef struct {logic w; logic [7:0] a; logic [7:0] d;} lpi_row_type;
	logic core_clk_in, rst_n_in, reg_wr_in, blink_in;
	logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, rd;
	logic [8:0] led_out, led_oe_out;
	int num_errors = 0, comparisons = 0;
	// writes and reads; reads expect d
	lpi_row_type rows [15] = '{'{1'b0, 8'h01, 8'hFF}, '{1'b0, 8'h09, 8'hFF},
		'{1'b0, 8'h0E, 8'h00}, '{1'b0, 8'h0F, 8'h30}, '{1'b0, 8'h10, 8'hFF},
		'{1'b1, 8'h01, 8'hA5}, '{1'b0, 8'h01, 8'hA5}, '{1'b1, 8'h09, 8'h3C},
		'{1'b0, 8'h09, 8'h3C}, '{1'b1, 8'h0F, 8'hFF}, '{1'b0, 8'h0F, 8'h37},
		'{1'b1, 8'h12, 8'h5A}, '{1'b0, 8'h12, 8'h5A}, '{1'b1, 8'h20, 8'h77},
		'{1'b0, 8'h20, 8'h00}};
	lpi_led_pwm u_lpi_led_pwm (.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rdata_out(reg_rdata_out), .blink_in(blink_in),
		.led_out(led_out), .led_oe_out(led_oe_out));
	lpi_host u_lpi_host (.core_clk_in(core_clk_in), .rdata_in(reg_rdata_out),
		.addr_out(reg_addr_in), .wdata_out(reg_wdata_in), .wr_out(reg_wr_in));
	// 25 MHz clock
	initial begin
		core_clk_in = 1'b0;
		forever #20 core_clk_in = ~core_clk_in;
	end
	task automatic check(input string n, input logic [11:0] s, e);
		comparisons++;
		if (s !== e) begin
			num_errors++;
			$display("Error: %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic do_reset;
		rst_n_in <= 1'b0;
		repeat (2) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
	endtask
	// pwm starts on the master write, so time the on-time of output 0
	task automatic pwm(input logic [7:0] m, cfg, i10, input int w,
		input logic o1);
		int c;
		do_reset;
		u_lpi_host.wr(8'h0F, cfg);
		u_lpi_host.wr(8'h10, i10);
		u_lpi_host.wr(8'h01, 8'hFD);
		u_lpi_host.wr(8'h0E, m);
		c = 0;
		while (!led_oe_out[0] && c < 3000) begin
			@(posedge core_clk_in) #1 c++;
		end
		// write and start latency allows a few cycles of slack
		check("on width", 12'(c >= w && c <= w + 4), 12'h001);
		check("oe1", 12'(led_oe_out[1]), 12'(o1));
		check("led", 12'(led_out), 12'h000);
		$display("pwm test done");
	endtask
	initial begin
		rst_n_in = 1'b0;
		blink_in = 1'b0;
		do_reset;
		foreach (rows[i]) begin
			if (rows[i].w)
				u_lpi_host.wr(rows[i].a, rows[i].d);
			else begin
				u_lpi_host.rd(rows[i].a, rd);
				check("rdata", 12'(rd), 12'(rows[i].d));
			end
		end
		$display("register test done");
		// one cycle is 781 clocks; static output 1 sinks (mixed setup)
		pwm(8'h10, 8'h00, 8'hF0, 781, 1'b1);
		pwm(8'h10, 8'h00, 8'hF2, 2343, 1'b1);
		pwm(8'h12, 8'h04, 8'hF0, 2343, 1'b0);
		pwm(8'h0F, 8'h00, 8'h00, 3000, 1'b1);
		do_reset;
		u_lpi_host.wr(8'h09, 8'h01);
		u_lpi_host.wr(8'h01, 8'hFE);
		// enable i[2], flip i[1], pin i[0]; ninth is high only in phase one
		for (int i = 0; i < 8; i++) begin
			u_lpi_host.wr(8'h0F, {2'h0, 1'b1, 3'h0, i[1], i[2]});
			blink_in <= i[0];
			repeat (6) @(posedge core_clk_in);
			#1 check("blink oe0", 12'(led_oe_out[0]),
				12'(!(i[2] & (i[1] ^ i[0]))));
			check("blink oe8", 12'(led_oe_out[8]),
				12'(!(i[2] & (i[1] ^ i[0]))));
		end
		$display("blink test done");
		results;
	end
	// watchdog well beyond the expected run length
	initial begin
		repeat (40000) @(posedge core_clk_in);
		num_errors++;
		results;
	end
endmodule
`default_nettype wire

// >>> tb/lpi_led_pwm_properties.sv
// port checker for the led pwm block
`timescale 1ns/100ps
`default_nettype none
module lpi_props (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	// register port
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_rdata_out,
	// pins
	input wire logic blink_in,
	input wire logic [8:0] led_out,
	input wire logic [8:0] led_oe_out
);
	logic [7:0] master_r;
	logic ben_r;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	// shadows of master value and blink enable
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			master_r <= 8'h00;
			ben_r <= 1'b0;
		end else if (reg_wr_in && reg_addr_in == 8'h0E) begin
			master_r <= reg_wdata_in;
		end else if (reg_wr_in && reg_addr_in == 8'h0F) begin
			ben_r <= reg_wdata_in[0];
		end
	end
	chk_pins_drain: assert property (led_out == 9'h000)
		else $error("led pin value not low");
	chk_reset_released: assert property ($rose(rst_n_in) |-> !led_oe_out)
		else $error("outputs not released after reset");
	chk_phase0_back: assert property ((reg_wr_in && reg_addr_in == 8'h01)
		##1 (reg_addr_in == 8'h01) |=>
		reg_rdata_out == $past(reg_wdata_in, 2)) else $error("phase0 readback");
	chk_phase1_back: assert property ((reg_wr_in && reg_addr_in == 8'h09)
		##1 (reg_addr_in == 8'h09) |=>
		reg_rdata_out == $past(reg_wdata_in, 2)) else $error("phase1 readback");
	chk_unmapped_zero: assert property (reg_addr_in == 8'h20 |=>
		reg_rdata_out == 8'h00) else $error("unmapped read not zero");
	chk_static_steady: assert property (master_r[7:4] == 4'h0 && !ben_r
		&& !reg_wr_in && !$past(reg_wr_in) |=> $stable(led_oe_out))
		else $error("static outputs moved");
	chk_static_level: assert property ((reg_wr_in && reg_addr_in == 8'h01 &&
		master_r[7:4] == 4'h0 && !ben_r) ##1 !reg_wr_in ##1 !reg_wr_in |=>
		led_oe_out[0] == ~$past(reg_wdata_in[0], 3)) else $error("static level");
	// status bit shows the pin two sync stages plus the read register late
	chk_config_back: assert property ($past(reg_addr_in) == 8'h0F |->
		reg_rdata_out[7] == 1'b0 && reg_rdata_out[3] == 1'b0 &&
		reg_rdata_out[6] == $past(blink_in, 3)) else $error("config readback");
endmodule
bind lpi_led_pwm lpi_props u_lpi_props (.core_clk_in(core_clk_in),
	.rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
	.reg_rdata_out(reg_rdata_out), .blink_in(blink_in),
	.led_out(led_out), .led_oe_out(led_oe_out));
`default_nettype wire
